// [verilog/mir_pkg.sv]
/*
 * Shared constants and types for the slave-id to route lookup block.
 * Assumes register numbers arrive as the 16-bit holding register number.
 */
package mir_pkg;

    // ------------------------------------------------------------------
    // Register numbers
    // ------------------------------------------------------------------
    localparam logic [15:0] REG_BAUD_TIMING     = 16'hB415;
    localparam logic [15:0] REG_EOM_TIME        = 16'hB419;
    localparam logic [15:0] REG_EOM_ADJUST      = 16'hB41D;
    localparam logic [15:0] REG_SLAVE_ID_OFFSET = 16'hB5A6;
    localparam logic [15:0] REG_SLAVE_COUNT_MAX = 16'hB5A7;
    localparam logic [15:0] REG_SLAVE_MAP_FIRST = 16'hB5A8;
    localparam logic [15:0] REG_FORM_COUNT      = 16'hB799;
    localparam logic [15:0] REG_FORM_ADDR_FIRST = 16'hB79A;
    localparam logic [15:0] REG_ROUTE_LINK_FIRST = 16'hB8C6;

    // ------------------------------------------------------------------
    // Table sizes
    // ------------------------------------------------------------------
    localparam int MAP_DEPTH_DEF  = 101;
    localparam int FORM_DEPTH_DEF = 300;

    // ------------------------------------------------------------------
    // Values and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] ADDR_UNUSED      = 16'hFFFF;
    localparam logic [15:0] BAUD_CODE_1200   = 16'h0004;
    localparam logic [15:0] BAUD_CODE_2400   = 16'h000B;
    localparam logic [15:0] EOM_ADJUST_ON    = 16'h0001;
    localparam logic [1:0]  DIP_CUSTOM       = 2'h3;
    localparam logic [15:0] BAUD_TIMING_DEF  = 16'h0000;
    localparam logic [15:0] EOM_TIME_DEF     = 16'h0000;
    localparam logic [15:0] EOM_ADJUST_DEF   = 16'h0000;
    localparam logic [15:0] SLAVE_OFFSET_DEF = 16'h0001;
    localparam logic [15:0] SLAVE_MAX_DEF    = 16'h0000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        BAUD_9600  = 3'b000,
        BAUD_19200 = 3'b001,
        BAUD_38400 = 3'b010,
        BAUD_1200  = 3'b011,
        BAUD_2400  = 3'b100,
        BAUD_BAD   = 3'b101
    } mir_baud_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SCAN = 2'b01,
        ST_DONE = 2'b10
    } mir_lk_state_t;

endpackage

// [verilog/mir_baud_decode.sv]
/*
 * Serial rate decode from switch inputs and the latched custom timing code.
 * Assumes the timing code is already the power-up copy.
 */
module mir_baud_decode (
    // Selection inputs
    input  wire logic [1:0]  dip_sw,
    input  wire logic [15:0] timing_code,
    // Decoded rate
    output mir_pkg::mir_baud_t baud
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    always_comb begin
        unique case (dip_sw)
            2'h0: baud = mir_pkg::BAUD_9600;
            2'h1: baud = mir_pkg::BAUD_19200;
            2'h2: baud = mir_pkg::BAUD_38400;
            2'h3: begin
                // Custom rate: unknown codes flag rather than guess a rate
                if (timing_code == mir_pkg::BAUD_CODE_1200) begin
                    baud = mir_pkg::BAUD_1200;
                end else if (timing_code == mir_pkg::BAUD_CODE_2400) begin
                    baud = mir_pkg::BAUD_2400;
                end else begin
                    baud = mir_pkg::BAUD_BAD;
                end
            end
        endcase
    end

endmodule

// [verilog/mir_route_scan.sv]
/*
 * Linear search of the formation table for one device address.
 * Assumes the table entry at idx is presented combinationally on entry.
 */
module mir_route_scan #(
    parameter int DEPTH = mir_pkg::FORM_DEPTH_DEF,
    parameter int IW    = $clog2(mir_pkg::FORM_DEPTH_DEF)
) (
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_b,
    // Search request
    input  wire logic          start,
    input  wire logic [15:0]   key,
    input  wire logic [15:0]   count,
    // Table access
    output logic      [IW-1:0] idx,
    input  wire logic [15:0]   entry,
    // Result
    output logic               done,
    output logic               hit
);

    logic          busy_r;
    logic [IW-1:0] idx_r;
    logic          done_r;
    logic          hit_r;
    logic [15:0]   idx_wide;

    assign idx_wide = {{(16 - IW){1'b0}}, idx_r};
    assign idx      = idx_r;
    assign done     = done_r;
    assign hit      = hit_r;

    // ------------------------------------------------------------------
    // Search walk, one entry a cycle; first match wins
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            busy_r <= 1'b0;
            idx_r  <= '0;
            done_r <= 1'b0;
            hit_r  <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (start) begin
                busy_r <= 1'b1;
                idx_r  <= '0;
                hit_r  <= 1'b0;
            end else if (busy_r) begin
                if (idx_wide >= count) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end else if (entry == key) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                    hit_r  <= 1'b1;
                end else if (idx_r == IW'(DEPTH - 1)) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end else begin
                    idx_r <= idx_r + 1'b1;
                end
            end
        end
    end

endmodule

// [verilog/mir_route_top.sv]
/*
 * Slave-id to device address translation and first-hop route lookup,
 * with the serial rate and end-of-message settings of the network master.
 * Assumes all inputs are synchronous to sys_clk and that cfg_default is
 * pulsed once to seed the retained settings before the first lookup.
 */
module mir_route_top #(
    parameter int MAP_DEPTH  = mir_pkg::MAP_DEPTH_DEF,
    parameter int FORM_DEPTH = mir_pkg::FORM_DEPTH_DEF
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst_b,
    // Register port
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    input  wire logic [15:0]  reg_addr,
    input  wire logic [15:0]  reg_wdata,
    output logic      [15:0]  reg_rdata_r,
    output logic              reg_rvalid_r,
    // Retained settings and serial rate
    input  wire logic         cfg_default,
    input  wire logic [1:0]   dip_sw,
    output mir_pkg::mir_baud_t baud_sel_r,
    output logic      [15:0]  eom_time_r,
    output logic              eom_extend_r,
    // Network formation
    input  wire logic         join_valid,
    input  wire logic [15:0]  join_addr,
    input  wire logic [15:0]  join_link,
    output logic              form_full_r,
    // Lookup request and result
    input  wire logic         lk_valid,
    input  wire logic [15:0]  lk_slave_id,
    output logic              lk_ready_r,
    output logic              rt_valid_r,
    output logic              rt_ignored_r,
    output logic              rt_found_r,
    output logic              rt_direct_r,
    output logic      [15:0]  rt_dev_r,
    output logic      [15:0]  rt_hop_r
);

    localparam int MIW = $clog2(MAP_DEPTH);
    localparam int FIW = $clog2(FORM_DEPTH);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [15:0]            map_r       [MAP_DEPTH];
    logic [15:0]            form_addr_r [FORM_DEPTH];
    logic [15:0]            form_link_r [FORM_DEPTH];
    logic [15:0]            form_count_r;
    logic [15:0]            timing_r;
    logic [15:0]            eom_time_cfg_r;
    logic [15:0]            eom_adj_r;
    logic [15:0]            slv_off_r;
    logic [15:0]            slv_max_r;
    logic [15:0]            act_timing_r;
    mir_pkg::mir_lk_state_t state_r;
    logic                   scan_start_r;
    mir_pkg::mir_baud_t     baud_dec;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic [15:0] map_off;
    logic [15:0] form_off;
    logic [15:0] link_off;
    logic        map_hit;
    logic        form_hit;
    logic        link_hit;
    logic [15:0] rd_data;

    assign map_off  = reg_addr - mir_pkg::REG_SLAVE_MAP_FIRST;
    assign form_off = reg_addr - mir_pkg::REG_FORM_ADDR_FIRST;
    assign link_off = reg_addr - mir_pkg::REG_ROUTE_LINK_FIRST;
    assign map_hit  = map_off < 16'(MAP_DEPTH);
    assign form_hit = form_off < form_count_r && form_off < 16'(FORM_DEPTH);
    assign link_hit = link_off < form_count_r && link_off < 16'(FORM_DEPTH);

    // ------------------------------------------------------------------
    // Retained settings; reset leaves them alone like nonvolatile cells
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (cfg_default) begin
            timing_r       <= mir_pkg::BAUD_TIMING_DEF;
            eom_time_cfg_r <= mir_pkg::EOM_TIME_DEF;
            eom_adj_r      <= mir_pkg::EOM_ADJUST_DEF;
            slv_off_r      <= mir_pkg::SLAVE_OFFSET_DEF;
            slv_max_r      <= mir_pkg::SLAVE_MAX_DEF;
        end else if (reg_wr) begin
            case (reg_addr)
                mir_pkg::REG_BAUD_TIMING:     timing_r       <= reg_wdata;
                mir_pkg::REG_EOM_TIME:        eom_time_cfg_r <= reg_wdata;
                mir_pkg::REG_EOM_ADJUST:      eom_adj_r      <= reg_wdata;
                mir_pkg::REG_SLAVE_ID_OFFSET: slv_off_r      <= reg_wdata;
                mir_pkg::REG_SLAVE_COUNT_MAX: slv_max_r      <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Slave-id map: entry k serves id offset+k
    always_ff @(posedge sys_clk) begin
        if (cfg_default) begin
            for (int i = 0; i < MAP_DEPTH; i++) begin
                map_r[i] <= mir_pkg::ADDR_UNUSED;
            end
        end else if (reg_wr && map_hit) begin
            map_r[map_off[MIW-1:0]] <= reg_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Power-up copies: writes only take hold across a reset
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            act_timing_r <= timing_r;
            eom_time_r   <= eom_time_cfg_r;
            eom_extend_r <= eom_adj_r == mir_pkg::EOM_ADJUST_ON;
            baud_sel_r   <= mir_pkg::BAUD_9600;
        end else begin
            baud_sel_r   <= baud_dec;
        end
    end

    mir_baud_decode u_baud (
        .dip_sw      (dip_sw),
        .timing_code (act_timing_r),
        .baud        (baud_dec)
    );

    // ------------------------------------------------------------------
    // Formation table, rebuilt after every reset
    // ------------------------------------------------------------------
    logic           join_ok;
    logic [FIW-1:0] form_wr_idx;

    assign join_ok     = join_valid && form_count_r < 16'(FORM_DEPTH);
    assign form_wr_idx = form_count_r[FIW-1:0];

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            form_count_r <= 16'h0000;
            form_full_r  <= 1'b0;
        end else begin
            if (join_ok) begin
                form_count_r <= form_count_r + 16'h0001;
            end
            form_full_r <= form_count_r + 16'(join_ok) >= 16'(FORM_DEPTH);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (join_ok) begin
            form_addr_r[form_wr_idx] <= join_addr;
            form_link_r[form_wr_idx] <= join_link;
        end
    end

    // ------------------------------------------------------------------
    // Register reads; unmapped and stale table rows read zero
    // ------------------------------------------------------------------
    always_comb begin
        rd_data = 16'h0000;
        if (map_hit) begin
            rd_data = map_r[map_off[MIW-1:0]];
        end else if (form_hit) begin
            rd_data = form_addr_r[form_off[FIW-1:0]];
        end else if (link_hit) begin
            rd_data = form_link_r[link_off[FIW-1:0]];
        end else begin
            case (reg_addr)
                mir_pkg::REG_BAUD_TIMING:     rd_data = timing_r;
                mir_pkg::REG_EOM_TIME:        rd_data = eom_time_cfg_r;
                mir_pkg::REG_EOM_ADJUST:      rd_data = eom_adj_r;
                mir_pkg::REG_SLAVE_ID_OFFSET: rd_data = slv_off_r;
                mir_pkg::REG_SLAVE_COUNT_MAX: rd_data = slv_max_r;
                mir_pkg::REG_FORM_COUNT:      rd_data = form_count_r;
                default:                      rd_data = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            reg_rvalid_r <= 1'b0;
            reg_rdata_r  <= 16'h0000;
        end else begin
            reg_rvalid_r <= reg_rd;
            if (reg_rd) begin
                reg_rdata_r <= rd_data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Id translation
    // ------------------------------------------------------------------
    logic [15:0] id_diff;
    logic        id_below;
    logic        id_over;
    logic [15:0] map_entry;
    logic        id_unused;
    logic        lk_take;
    logic        lk_skip;

    assign id_diff   = lk_slave_id - slv_off_r;
    assign id_below  = lk_slave_id < slv_off_r;
    assign id_over   = id_diff >= slv_max_r || id_diff >= 16'(MAP_DEPTH);
    assign map_entry = id_over ? mir_pkg::ADDR_UNUSED : map_r[id_diff[MIW-1:0]];
    assign id_unused = map_entry == mir_pkg::ADDR_UNUSED;
    assign lk_take   = lk_valid && lk_ready_r;
    assign lk_skip   = id_below || id_over || id_unused;

    // ------------------------------------------------------------------
    // Route search
    // ------------------------------------------------------------------
    logic [FIW-1:0] scan_idx;
    logic           scan_done;
    logic           scan_hit;
    logic [15:0]    hit_link;

    mir_route_scan #(
        .DEPTH (FORM_DEPTH),
        .IW    (FIW)
    ) u_scan (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .start   (scan_start_r),
        .key     (rt_dev_r),
        .count   (form_count_r),
        .idx     (scan_idx),
        .entry   (form_addr_r[scan_idx]),
        .done    (scan_done),
        .hit     (scan_hit)
    );

    assign hit_link = form_link_r[scan_idx];

    // ------------------------------------------------------------------
    // Lookup sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_r      <= mir_pkg::ST_IDLE;
            lk_ready_r   <= 1'b0;
            scan_start_r <= 1'b0;
            rt_valid_r   <= 1'b0;
            rt_ignored_r <= 1'b0;
            rt_found_r   <= 1'b0;
            rt_direct_r  <= 1'b0;
            rt_dev_r     <= mir_pkg::ADDR_UNUSED;
            rt_hop_r     <= mir_pkg::ADDR_UNUSED;
        end else begin
            rt_valid_r   <= 1'b0;
            scan_start_r <= 1'b0;
            unique case (state_r)
                mir_pkg::ST_IDLE: begin
                    lk_ready_r <= 1'b1;
                    if (lk_take) begin
                        // Address latched once; the search never sees the id
                        lk_ready_r  <= 1'b0;
                        rt_dev_r    <= map_entry;
                        rt_found_r  <= 1'b0;
                        rt_direct_r <= 1'b0;
                        rt_hop_r    <= mir_pkg::ADDR_UNUSED;
                        if (lk_skip) begin
                            rt_valid_r   <= 1'b1;
                            rt_ignored_r <= 1'b1;
                            state_r      <= mir_pkg::ST_DONE;
                        end else begin
                            rt_ignored_r <= 1'b0;
                            scan_start_r <= 1'b1;
                            state_r      <= mir_pkg::ST_SCAN;
                        end
                    end
                end
                mir_pkg::ST_SCAN: begin
                    if (scan_done) begin
                        rt_valid_r <= 1'b1;
                        rt_found_r <= scan_hit;
                        if (scan_hit) begin
                            rt_direct_r <= hit_link == rt_dev_r;
                            rt_hop_r    <= hit_link;
                        end
                        state_r <= mir_pkg::ST_DONE;
                    end
                end
                mir_pkg::ST_DONE: begin
                    lk_ready_r <= 1'b1;
                    state_r    <= mir_pkg::ST_IDLE;
                end
                default: state_r <= mir_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_count_on_join: assert property (join_ok |=> form_count_r == $past(form_count_r) + 16'h0001)
        else $error("Radio count did not advance on join");
    a_join_addr_slot: assert property (join_ok |=> form_addr_r[$past(form_wr_idx)] == $past(join_addr))
        else $error("Joined address not at next slot");
    a_link_same_slot: assert property (join_ok |=> form_link_r[$past(form_wr_idx)] == $past(join_link))
        else $error("Link not stored beside its address");
    a_direct_when_equal: assert property (rt_valid_r && rt_found_r |-> rt_direct_r == (rt_hop_r == rt_dev_r))
        else $error("Direct flag disagrees with link");
    a_hop_from_link: assert property (state_r == mir_pkg::ST_SCAN && scan_done && scan_hit |=> rt_valid_r && rt_found_r && rt_hop_r == $past(hit_link))
        else $error("First hop not taken from link entry");
    a_ignore_below_off: assert property (lk_take && id_below |=> rt_valid_r && rt_ignored_r && !rt_found_r)
        else $error("Id below offset was not ignored");
    a_unused_entry_skip: assert property (lk_take && !id_below && !id_over && id_unused |=> rt_ignored_r && !scan_start_r)
        else $error("Unused map entry started a search");
    a_over_max_skip: assert property (lk_take && id_diff >= slv_max_r |=> rt_valid_r && rt_ignored_r ##1 !rt_valid_r)
        else $error("Id above maximum produced a route");
    a_rate_held_till_rst: assert property (reg_wr && reg_addr == mir_pkg::REG_BAUD_TIMING |=> $stable(act_timing_r) [*2])
        else $error("Timing applied without reset");
    a_custom_1200: assert property (dip_sw == mir_pkg::DIP_CUSTOM && act_timing_r == mir_pkg::BAUD_CODE_1200 |=> baud_sel_r == mir_pkg::BAUD_1200)
        else $error("Code 0x04 did not give 1200 baud");
    a_address_only: assert property (state_r == mir_pkg::ST_SCAN && $past(state_r) == mir_pkg::ST_SCAN |-> $stable(rt_dev_r))
        else $error("Device address changed during search");

endmodule

// [verif/mir_host_model.sv]
/* Host model: register port master for the lookup block.
   Assumes the bench calls its tasks; drives on the falling edge. */
module mir_host_model (
    // Clock and answer
    input  wire logic        sys_clk,
    input  wire logic [15:0] reg_rdata_r,
    input  wire logic        reg_rvalid_r,
    // Requests
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [15:0]      reg_addr,
    output logic [15:0]      reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
    end
    task automatic wr(input logic [15:0] a, d);
        @(negedge sys_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    // Released address is inverted so a stale match cannot pass
    task automatic rd(input logic [15:0] a, output logic [15:0] q, output logic v);
        @(negedge sys_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        v = reg_rvalid_r;
        q = reg_rdata_r;
    endtask
    task automatic set_1200();
        wr(mir_pkg::REG_BAUD_TIMING, mir_pkg::BAUD_CODE_1200);
        wr(mir_pkg::REG_EOM_TIME, 16'h00FF);
        wr(mir_pkg::REG_EOM_ADJUST, mir_pkg::EOM_ADJUST_ON);
    endtask
endmodule

// [verif/modbus_id_route_lookup_tb_top.sv]
/* Bench for the lookup block: joins, map setup, lookups, custom rate.
   Assumes the design's defaults for table depths. */
module modbus_id_route_lookup_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rst_b, cfg_default, join_valid, lk_valid, reg_wr, reg_rd, reg_rvalid_r, v;
    logic eom_extend_r, lk_ready_r, rt_valid_r, rt_ignored_r, rt_found_r, rt_direct_r, form_full_r;
    logic [1:0]  dip_sw;
    logic [15:0] join_addr, join_link, lk_slave_id, reg_addr, reg_wdata, reg_rdata_r, q;
    logic [15:0] eom_time_r, rt_dev_r, rt_hop_r;
    mir_pkg::mir_baud_t baud_sel_r;
    int          errors, comparisons, cyc;
    logic [15:0] ja[3] = '{16'hD431, 16'h3039, 16'h5BA0};
    logic [15:0] jl[3] = '{16'hD431, 16'h5BA0, 16'h5BA0};
    logic [15:0] mp[5] = '{16'hD431, 16'hFFFF, 16'h1111, 16'h5BA0, 16'h3039};
    mir_route_top dut_u (.sys_clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_r,
        .reg_rvalid_r, .cfg_default, .dip_sw, .baud_sel_r, .eom_time_r, .eom_extend_r, .join_valid,
        .join_addr, .join_link, .form_full_r, .lk_valid, .lk_slave_id, .lk_ready_r, .rt_valid_r,
        .rt_ignored_r, .rt_found_r, .rt_direct_r, .rt_dev_r, .rt_hop_r);
    mir_host_model host_u (.sys_clk, .reg_rdata_r, .reg_rvalid_r, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
    always #50 sys_clk = ~sys_clk;
    task automatic end_sim();
        if (errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            end_sim();
        end
    end
    task automatic check(input string n, input logic [15:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic rchk(input logic [15:0] a, exp);
        host_u.rd(a, q, v);
        check("reg_rvalid", {15'h0, v}, 16'h0001);
        check("reg_rdata", q, exp);
    endtask
    task automatic rst_pulse(input int n);
        @(negedge sys_clk);
        rst_b = 1'b0;
        repeat (n) @(negedge sys_clk);
        rst_b = 1'b1;
        @(negedge sys_clk);
    endtask
    task automatic lookup(input logic [15:0] id, input logic ign, fnd, dir, input logic [15:0] dev, hop);
        for (int n = 0; n < 40 && lk_ready_r !== 1'b1; n++) @(negedge sys_clk);
        lk_valid = 1'b1;
        lk_slave_id = id;
        @(negedge sys_clk);
        lk_valid = 1'b0;
        lk_slave_id = ~id;
        for (int n = 0; n < 40 && rt_valid_r !== 1'b1; n++) @(negedge sys_clk);
        check("rt_flags", {rt_valid_r, rt_ignored_r, rt_found_r, rt_direct_r}, {1'b1, ign, fnd, dir});
        check("rt_dev", rt_dev_r, dev);
        check("rt_hop", rt_hop_r, hop);
    endtask
    initial begin
        {sys_clk, rst_b, join_valid, lk_valid, dip_sw} = '0;
        {join_addr, join_link, lk_slave_id, errors, comparisons, cyc} = '0;
        cfg_default = 1'b1;
        rst_pulse(12);
        cfg_default = 1'b0;
        for (int i = 0; i < 3; i++) begin
            dip_sw = 2'(i);
            @(negedge sys_clk);
            check("baud", {13'h0, baud_sel_r}, 16'(i));
        end
        for (int i = 0; i < 3; i++) begin
            join_valid = 1'b1;
            join_addr = ja[i];
            join_link = jl[i];
            @(negedge sys_clk);
        end
        join_valid = 1'b0;
        host_u.wr(mir_pkg::REG_FORM_COUNT, 16'h0009);
        rchk(mir_pkg::REG_FORM_COUNT, 16'h0003);
        for (int i = 0; i < 3; i++) begin
            rchk(mir_pkg::REG_FORM_ADDR_FIRST + 16'(i), ja[i]);
            rchk(mir_pkg::REG_ROUTE_LINK_FIRST + 16'(i), jl[i]);
        end
        host_u.wr(mir_pkg::REG_SLAVE_ID_OFFSET, 16'h000B);
        host_u.wr(mir_pkg::REG_SLAVE_COUNT_MAX, 16'h0032);
        for (int i = 0; i < 5; i++)
            host_u.wr(mir_pkg::REG_SLAVE_MAP_FIRST + 16'(i), mp[i]);
        rchk(mir_pkg::REG_SLAVE_ID_OFFSET, 16'h000B);
        lookup(16'd10, 1, 0, 0, 16'hFFFF, 16'hFFFF);
        lookup(16'd11, 0, 1, 1, 16'hD431, 16'hD431);
        lookup(16'd15, 0, 1, 0, 16'h3039, 16'h5BA0);
        lookup(16'd14, 0, 1, 1, 16'h5BA0, 16'h5BA0);
        lookup(16'd12, 1, 0, 0, 16'hFFFF, 16'hFFFF);
        lookup(16'd61, 1, 0, 0, 16'hFFFF, 16'hFFFF);
        lookup(16'd13, 0, 0, 0, 16'h1111, 16'hFFFF);
        dip_sw = 2'h3;
        host_u.set_1200();
        @(negedge sys_clk);
        check("baud", {13'h0, baud_sel_r}, {13'h0, mir_pkg::BAUD_BAD});
        check("eom_time", eom_time_r, 16'h0000);
        rst_pulse(2);
        check("baud", {13'h0, baud_sel_r}, {13'h0, mir_pkg::BAUD_1200});
        check("eom_time", eom_time_r, 16'h00FF);
        check("eom_extend", {15'h0, eom_extend_r}, 16'h0001);
        host_u.wr(mir_pkg::REG_BAUD_TIMING, mir_pkg::BAUD_CODE_2400);
        rst_pulse(2);
        check("baud", {13'h0, baud_sel_r}, {13'h0, mir_pkg::BAUD_2400});
        check("form_full", {15'h0, form_full_r}, 16'h0000);
        join_valid = 1'b1;
        for (int i = 0; i < 301; i++) begin
            join_addr = 16'(i);
            join_link = 16'(i);
            @(negedge sys_clk);
        end
        join_valid = 1'b0;
        check("form_full", {15'h0, form_full_r}, 16'h0001);
        rchk(mir_pkg::REG_FORM_COUNT, 16'h012C);
        end_sim();
    end
endmodule
